// ==== hdl/epi_defines.svh ====
`ifndef EPI_DEFINES_SVH
`define EPI_DEFINES_SVH
// ============================================================
// register byte offsets
`define EPI_OFS_MCU_CONTROL 8'h00
`define EPI_OFS_ENABLE 8'h04
`define EPI_OFS_FLAGS 8'h08
`define EPI_OFS_PC_MASK 8'h0C
`define EPI_OFS_EVT_STATUS 8'h10
`define EPI_OFS_EVT_MASK 8'h14
// ============================================================
// field positions
`define EPI_BIT_SENSE_LO 0
`define EPI_BIT_SENSE_HI 1
`define EPI_BIT_SLEEP_LO 3
`define EPI_BIT_SLEEP_HI 4
`define EPI_BIT_SLEEP_PERMIT 5
`define EPI_BIT_PUD 6
`define EPI_BIT_EXT 6
`define EPI_BIT_PC 5
`define EPI_BIT_EVT_EXT 0
`define EPI_BIT_EVT_PC 1
// ============================================================
// writable masks and reset values
`define EPI_MCU_WMASK 8'h7B
`define EPI_EN_WMASK 8'h60
`define EPI_PCM_WMASK 8'h3F
`define EPI_EVT_WMASK 8'h03
`define EPI_RST_MCU 8'h00
`define EPI_RST_EN 8'h00
`define EPI_RST_PCM 8'h00
`define EPI_RST_EVT 8'h00
`define EPI_PINS 6
`define EPI_EXT_PIN 1
`endif

// ==== hdl/epi_pkg.sv ====
package epi_pkg;
  // sense field encodings, gray along low->change->fall->rise is not
  // meaningful here: the codes are fixed by the control register
  typedef enum logic [1:0] {
    EPI_SENSE_LOW = 2'h0,
    EPI_SENSE_ANY = 2'h1,
    EPI_SENSE_FALL = 2'h2,
    EPI_SENSE_RISE = 2'h3
  } epi_sense_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } epi_wb_req_s;

  typedef struct packed {
    logic ext;
    logic pc;
  } epi_irq_s;
endpackage

// ==== hdl/epi_top.sv ====
`timescale 1ns/1ps
`include "epi_defines.svh"
// Notes on behaviour
// (R01) sense field: 00 low level, 01 any change, 10 falling, 11 rising
// (R02) external request only with global enable and external enable set
// (R03) pin sampled before edge detection; pulses over one clock caught
// (R04) source must hold low level until current instruction completes
// (R05) enabled level mode requests continuously while the pin stays low
// (R06) edges need io clock; low level detected without it
// (R07) pin changes detected without the io clock, able to wake
// (R08) pin activity triggers even when pins are outputs
// (R09) pin change counts only with its mask bit and global enable
// (R10) external flag bit 6 set by edge, cleared by vector or write one
// (R11) external flag held clear while low level sensing is selected
// (R12) pin change flag bit 5 set by change, cleared by vector or write one
// (R13) low level gone before start-up end: wake but no interrupt
// (R14) reserved bits of control, enable, flag, mask read zero
// (R15) pull-up disable bit 6 turns off every port pull-up
// (R16) input gating overridden by mask and enable, or analog disable
// (R17) clamp released on external pin only while its request is enabled; code also releases it while its masked pin change is enabled
// (R18) high clamped edge pin sets its flag when deep sleep ends; code sets it in rising and any-change modes only, not falling
// (R19) external pin two-flop synchronised, previous sample kept
module epi_top #(
  parameter int N_PINS = `EPI_PINS,
  parameter int EXT_PIN = `EPI_EXT_PIN
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // wishbone slave
  input wire epi_pkg::epi_wb_req_s wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core side
  input wire logic core_status_word_i,
  input wire logic io_clk_en,
  input wire logic deep_sleep,
  input wire logic vector_ack_ext,
  input wire logic vector_ack_pc,
  output epi_pkg::epi_irq_s irq_req,
  output logic irq,
  output logic wake_req,
  // port pins and pad control
  input wire logic [N_PINS-1:0] pin_change_inputs,
  input wire logic [N_PINS-1:0] analog_input_digital_off,
  output logic [N_PINS-1:0] input_gate_override_enable,
  output logic [N_PINS-1:0] input_gate_override_value,
  output logic global_pullup_disable,
  output logic sleep_permit,
  output logic [1:0] sleep_select
);
  if (N_PINS < 1 || N_PINS > 8 || EXT_PIN >= N_PINS || EXT_PIN < 0) begin : g_bad_params
    $error("epi_top: pin count or external pin index out of range");
  end

  // ==========================================================
  // registers
  logic [7:0] mcu_control;
  logic [7:0] ext_irq_enable;
  logic [7:0] pin_change_mask;
  logic [7:0] evt_status;
  logic [7:0] evt_mask;
  logic ext_irq_flag;
  logic pin_change_flag;
  logic [1:0] sense;
  logic ext_en;
  logic pc_en;
  assign sense = mcu_control[`EPI_BIT_SENSE_HI:`EPI_BIT_SENSE_LO];
  assign ext_en = ext_irq_enable[`EPI_BIT_EXT];
  assign pc_en = ext_irq_enable[`EPI_BIT_PC];

  // ==========================================================
  // bus decode
  logic acc;
  logic wr;
  logic [7:0] wd;
  assign acc = wb_req.cyc && wb_req.stb && !wb_ack_o;
  assign wr = acc && wb_req.we && wb_req.sel[0];
  assign wd = wb_req.dat[7:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mcu_control <= `EPI_RST_MCU;
      ext_irq_enable <= `EPI_RST_EN;
      pin_change_mask <= `EPI_RST_PCM;
      evt_mask <= `EPI_RST_EVT;
    end else if (wr) begin
      // reserved bits never store, so they read back zero
      unique case (wb_req.adr)
        `EPI_OFS_MCU_CONTROL: mcu_control <= wd & `EPI_MCU_WMASK; // R14
        `EPI_OFS_ENABLE: ext_irq_enable <= wd & `EPI_EN_WMASK; // R14
        `EPI_OFS_PC_MASK: pin_change_mask <= wd & `EPI_PCM_WMASK; // R14
        `EPI_OFS_EVT_MASK: evt_mask <= wd & `EPI_EVT_WMASK;
        default: begin
        end
      endcase
    end
  end

  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    unique case (wb_req.adr)
      `EPI_OFS_MCU_CONTROL: rd = mcu_control;
      `EPI_OFS_ENABLE: rd = ext_irq_enable;
      `EPI_OFS_FLAGS: begin
        rd[`EPI_BIT_EXT] = ext_irq_flag;
        rd[`EPI_BIT_PC] = pin_change_flag;
      end
      `EPI_OFS_PC_MASK: rd = pin_change_mask;
      `EPI_OFS_EVT_STATUS: rd = evt_status;
      `EPI_OFS_EVT_MASK: rd = evt_mask;
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc) begin
      wb_dat_o <= {24'h00_0000, rd};
    end
  end

  // ==========================================================
  // pin synchronisers and sleep clamp
  logic [N_PINS-1:0] pin_meta;
  logic [N_PINS-1:0] pin_sync;
  logic [N_PINS-1:0] pin_eff;
  logic [N_PINS-1:0] pc_prev;
  logic [N_PINS-1:0] pin_keep;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_change_inputs; // R19
      pin_sync <= pin_meta; // R19
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_PINS; g++) begin : g_pin
      logic keep;
      // the ext pin stays live while its request, or its masked pin change request, is enabled
      if (g == EXT_PIN) begin : g_ext
        assign keep = ext_en || (pc_en && pin_change_mask[g]); // R17
      end else begin : g_pc
        assign keep = pc_en && pin_change_mask[g]; // R16
      end
      assign pin_keep[g] = keep;
      // a clamped pin reads low; releasing the clamp looks like a rise
      assign pin_eff[g] = pin_sync[g] && (keep || !deep_sleep); // R18
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          input_gate_override_enable[g] <= 1'b0;
          input_gate_override_value[g] <= 1'b0;
        end else begin
          input_gate_override_enable[g] <= keep || analog_input_digital_off[g]; // R16
          input_gate_override_value[g] <= analog_input_digital_off[g]; // R16
        end
      end
    end
  endgenerate

  // ==========================================================
  // external pin detection
  logic ext_now;
  logic ext_prev;
  logic ext_rise;
  logic ext_fall;
  logic ext_hit;
  logic ext_level;
  assign ext_now = pin_eff[EXT_PIN];
  // edges need the io clock; it is halted in deep sleep
  assign ext_rise = io_clk_en && ext_now && !ext_prev; // R06
  assign ext_fall = io_clk_en && !ext_now && ext_prev; // R06
  assign ext_level = sense == epi_pkg::EPI_SENSE_LOW; // R01

  always_comb begin
    unique case (epi_pkg::epi_sense_e'(sense)) // R01
      epi_pkg::EPI_SENSE_LOW: ext_hit = 1'b0;
      epi_pkg::EPI_SENSE_ANY: ext_hit = ext_rise || ext_fall;
      epi_pkg::EPI_SENSE_FALL: ext_hit = ext_fall;
      epi_pkg::EPI_SENSE_RISE: ext_hit = ext_rise;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_prev <= 1'b0;
    end else if (io_clk_en || (deep_sleep && !pin_keep[EXT_PIN])) begin
      // a clamped pin is sampled low even with the io clock halted, so
      // releasing the clamp on resume reads as a rise whenever the pin is high
      ext_prev <= ext_now; // R03 R19 R18
    end
  end

  logic clr_ext;
  logic clr_pc;
  assign clr_ext = vector_ack_ext ||
                   (wr && wb_req.adr == `EPI_OFS_FLAGS && wd[`EPI_BIT_EXT]);
  assign clr_pc = vector_ack_pc ||
                  (wr && wb_req.adr == `EPI_OFS_FLAGS && wd[`EPI_BIT_PC]);

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_irq_flag <= 1'b0;
    end else if (ext_level) begin
      ext_irq_flag <= 1'b0; // R11
    end else if (ext_hit) begin
      ext_irq_flag <= 1'b1; // R10 R08
    end else if (clr_ext) begin
      ext_irq_flag <= 1'b0; // R10
    end
  end

  // ==========================================================
  // pin change detection, runs without the io clock enable
  logic pc_hit;
  assign pc_hit = pc_en && |((pin_eff ^ pc_prev) & pin_change_mask[N_PINS-1:0]); // R09 R07

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pc_prev <= '0;
    end else begin
      pc_prev <= pin_eff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_change_flag <= 1'b0;
    end else if (pc_hit) begin
      pin_change_flag <= 1'b1; // R12 R08
    end else if (clr_pc) begin
      pin_change_flag <= 1'b0; // R12
    end
  end

  // ==========================================================
  // requests to the core and wake
  logic ext_req_next;
  logic level_low;
  assign level_low = ext_level && !ext_now && ext_en;
  // a level that vanished before start-up yields no request
  assign ext_req_next = core_status_word_i && ext_en &&
                        (ext_level ? !ext_now : ext_irq_flag); // R02 R05 R13

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_req <= '0;
      wake_req <= 1'b0;
    end else begin
      irq_req.ext <= ext_req_next;
      irq_req.pc <= core_status_word_i && pc_en && pin_change_flag;
      wake_req <= level_low || pc_hit; // R06 R07 R13
    end
  end

  // ==========================================================
  // event status and interrupt line
  logic [7:0] evt_set;
  always_comb begin
    evt_set = 8'h00;
    evt_set[`EPI_BIT_EVT_EXT] = ext_hit || level_low;
    evt_set[`EPI_BIT_EVT_PC] = pc_hit;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evt_status <= `EPI_RST_EVT;
    end else if (wr && wb_req.adr == `EPI_OFS_EVT_STATUS) begin
      evt_status <= (evt_status & ~wd) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_mask);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      global_pullup_disable <= 1'b0;
      sleep_permit <= 1'b0;
      sleep_select <= 2'h0;
    end else begin
      global_pullup_disable <= mcu_control[`EPI_BIT_PUD]; // R15
      sleep_permit <= mcu_control[`EPI_BIT_SLEEP_PERMIT];
      sleep_select <= mcu_control[`EPI_BIT_SLEEP_HI:`EPI_BIT_SLEEP_LO];
    end
  end

  // ==========================================================
  // checks
  sequence s_rise_seen;
    sense == 2'h3 && io_clk_en && ext_now && !ext_prev && !rst;
  endsequence
  sequence s_fall_seen;
    sense == 2'h2 && io_clk_en && !ext_now && ext_prev && !rst;
  endsequence
  sequence s_clamp_high;
    deep_sleep && !pin_keep[EXT_PIN] && pin_sync[EXT_PIN];
  endsequence
  sequence s_resume_rise;
    !deep_sleep && io_clk_en && pin_sync[EXT_PIN] && (sense == 2'h1 || sense == 2'h3);
  endsequence

  AST_RISE_SETS: assert property (@(posedge ref_clk) disable iff (rst) // R10
    s_rise_seen |=> ext_irq_flag) else $error("rising edge lost");
  AST_FALL_SETS: assert property (@(posedge ref_clk) disable iff (rst) // R01
    s_fall_seen |=> ext_irq_flag) else $error("falling edge lost");
  AST_LEVEL_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // R11
    sense == 2'h0 |=> !ext_irq_flag) else $error("flag set in level mode");
  AST_EXT_GATED: assert property (@(posedge ref_clk) disable iff (rst) // R02
    $rose(irq_req.ext) |-> $past(core_status_word_i && ext_en))
    else $error("external request without enables");
  AST_LEVEL_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // R05
    (sense == 2'h0 && ext_en && core_status_word_i && !ext_now) [*2] |=> irq_req.ext)
    else $error("level request dropped");
  AST_PC_MASKED: assert property (@(posedge ref_clk) disable iff (rst) // R09
    pc_hit |-> pc_en && |(pin_change_mask[N_PINS-1:0] & (pin_eff ^ pc_prev)))
    else $error("unmasked pin change");
  AST_PC_SETS: assert property (@(posedge ref_clk) disable iff (rst) // R12
    pc_hit |=> pin_change_flag ##1 (pin_change_flag || $past(clr_pc)))
    else $error("pin change flag not set");
  AST_SYNC_DELAY: assert property (@(posedge ref_clk) disable iff (rst) // R19
    $changed(pin_change_inputs[EXT_PIN]) ##2 !deep_sleep |-> 
    pin_eff[EXT_PIN] == $past(pin_change_inputs[EXT_PIN], 2))
    else $error("synchroniser depth wrong");
  AST_PUD: assert property (@(posedge ref_clk) disable iff (rst) // R15
    mcu_control[6] |=> global_pullup_disable) else $error("pull-ups not off");
  AST_RSVD: assert property (@(posedge ref_clk) disable iff (rst) // R14
    mcu_control[7] == 1'b0 && mcu_control[2] == 1'b0 && pin_change_mask[7:6] == 2'h0)
    else $error("reserved bit stored");
  AST_RESUME_FLAG: assert property (@(posedge ref_clk) disable iff (rst) // R18
    s_clamp_high ##1 s_resume_rise |=> ext_irq_flag)
    else $error("clamp release did not set the flag");
  AST_CLAMP_OPEN: assert property (@(posedge ref_clk) disable iff (rst) // R17
    deep_sleep && ext_en |-> pin_eff[EXT_PIN] == pin_sync[EXT_PIN])
    else $error("enabled external pin clamped");
  AST_CLAMP_SHUT: assert property (@(posedge ref_clk) disable iff (rst) // R17
    deep_sleep && !pin_keep[EXT_PIN] |-> !pin_eff[EXT_PIN])
    else $error("disabled external pin not clamped");
  AST_EDGE_NEEDS_CLK: assert property (@(posedge ref_clk) disable iff (rst) // R06
    !io_clk_en && !ext_irq_flag |=> !ext_irq_flag)
    else $error("edge flagged without io clock");
  AST_LEVEL_WAKE: assert property (@(posedge ref_clk) disable iff (rst) // R06
    sense == 2'h0 && ext_en && !ext_now |=> wake_req)
    else $error("low level did not wake");
  AST_LEVEL_GONE: assert property (@(posedge ref_clk) disable iff (rst) // R13
    sense == 2'h0 && ext_en && ext_now |=> !irq_req.ext)
    else $error("request kept after level vanished");
  AST_PC_NO_CLK: assert property (@(posedge ref_clk) disable iff (rst) // R07
    !io_clk_en && pc_hit |=> wake_req && pin_change_flag)
    else $error("pin change lost without io clock");
  AST_GATE_OVR: assert property (@(posedge ref_clk) disable iff (rst) // R16
    !pc_en && !ext_en |=> input_gate_override_enable == $past(analog_input_digital_off))
    else $error("input gating override wrong");
endmodule // epi_top

// ==== dv/epi_pin_model.sv ====
`timescale 1ns/1ps
// ==========
// far-side pin driver: puts the bench's wanted levels on the pads
module epi_pin_model (
  // clock
  input wire logic ref_clk,
  // wanted levels and pace
  input wire logic [5:0] target,
  input wire logic slow,
  // pads
  output logic [5:0] pins
);
  logic [5:0] lag;
  initial pins = 6'h00;
  initial lag = 6'h00;
  // slow pace trails one more edge, as a weak external source would
  always @(posedge ref_clk) begin
    lag <= target;
    pins <= slow ? lag : target;
  end
endmodule // epi_pin_model

// ==== dv/external_pin_interrupts_tb.sv ====
`timescale 1ns/1ps
`include "epi_defines.svh"
module external_pin_interrupts_tb;
  logic ref_clk, rst, core_status_word_i, io_clk_en, deep_sleep, slow;
  logic vector_ack_ext, vector_ack_pc, wb_ack_o, irq, global_pullup_disable;
  epi_pkg::epi_wb_req_s wb_req;
  epi_pkg::epi_irq_s irq_req;
  logic [31:0] wb_dat_o;
  logic [5:0] pin_tgt, pins, analog, ige, igv, mk;
  logic [7:0] q;
  logic wake_req, sleep_permit;
  logic [1:0] sleep_select;
  int err_total, cmp_count, seed, k;

  epi_top i_epi_top (.ref_clk(ref_clk), .rst(rst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .core_status_word_i(core_status_word_i), .io_clk_en(io_clk_en),
    .deep_sleep(deep_sleep), .vector_ack_ext(vector_ack_ext), .vector_ack_pc(vector_ack_pc),
    .irq_req(irq_req), .irq(irq), .wake_req(wake_req), .pin_change_inputs(pins),
    .analog_input_digital_off(analog), .input_gate_override_enable(ige),
    .input_gate_override_value(igv), .global_pullup_disable(global_pullup_disable),
    .sleep_permit(sleep_permit), .sleep_select(sleep_select));
  epi_pin_model i_epi_pin_model (.ref_clk(ref_clk), .target(pin_tgt), .slow(slow), .pins(pins));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ==========
  // checking and bus helpers
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task finish_test;
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // classic single cycle; the ack is waited for, never assumed
  task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h00_0000, d}};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    q = wb_dat_o[7:0];
    wb_req <= '0;
    if (n >= 16) begin
      err_total++;
      $display("ERROR %0t bus answer missing", $time);
      finish_test;
    end
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk({24'h00_0000, q}, {24'h00_0000, e});
  endtask

  task pin(input logic [5:0] v);
    @(posedge ref_clk);
    pin_tgt <= v;
    repeat (10) @(posedge ref_clk);
  endtask

  function logic hit(input logic [1:0] m, input logic a, input logic b);
    case (m)
      2'h1: hit = a ^ b;
      2'h2: hit = a & ~b;
      2'h3: hit = ~a & b;
      default: hit = 1'b0;
    endcase
  endfunction

  // ==========
  // main sequence
  initial begin
    seed = 98;
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    wb_req = '0;
    core_status_word_i = 1'b0;
    io_clk_en = 1'b1;
    deep_sleep = 1'b0;
    vector_ack_ext = 1'b0;
    vector_ack_pc = 1'b0;
    slow = 1'b0;
    pin_tgt = 6'h00;
    analog = 6'h00;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`EPI_OFS_MCU_CONTROL, 8'h00);
    rd(`EPI_OFS_FLAGS, 8'h00);
    wb(1'b1, `EPI_OFS_MCU_CONTROL, 8'hFF);
    rd(`EPI_OFS_MCU_CONTROL, 8'h7B);
    chk(global_pullup_disable, 1'b1);
    chk({sleep_permit, sleep_select}, 3'h7);
    wb(1'b1, `EPI_OFS_ENABLE, 8'hFF);
    rd(`EPI_OFS_ENABLE, 8'h60);
    wb(1'b1, `EPI_OFS_PC_MASK, 8'hFF);
    rd(`EPI_OFS_PC_MASK, 8'h3F);
    rd(8'h18, 8'h00);
    wb(1'b1, `EPI_OFS_PC_MASK, 8'h00);
    wb(1'b1, `EPI_OFS_ENABLE, 8'h40);
    core_status_word_i <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      slow <= 1'($random(seed));
      wb(1'b1, `EPI_OFS_MCU_CONTROL, m[7:0]);
      wb(1'b1, `EPI_OFS_FLAGS, 8'h60);
      pin(6'h02);
      rd(`EPI_OFS_FLAGS, {1'b0, hit(m[1:0], 1'b0, 1'b1), 6'h00});
      chk(irq_req.ext, hit(m[1:0], 1'b0, 1'b1));
      @(posedge ref_clk) vector_ack_ext <= 1'b1;
      @(posedge ref_clk) vector_ack_ext <= 1'b0;
      rd(`EPI_OFS_FLAGS, 8'h00);
      pin(6'h00);
      rd(`EPI_OFS_FLAGS, {1'b0, hit(m[1:0], 1'b1, 1'b0), 6'h00});
      wb(1'b1, `EPI_OFS_FLAGS, 8'h60);
    end
    // a three-cycle pulse in rising mode must not be lost
    pin_tgt <= 6'h02;
    repeat (2) @(posedge ref_clk);
    pin(6'h00);
    rd(`EPI_OFS_FLAGS, 8'h40);
    // a rise while the io clock is halted is held back until it runs again
    wb(1'b1, `EPI_OFS_FLAGS, 8'h60);
    io_clk_en <= 1'b0;
    pin(6'h02);
    rd(`EPI_OFS_FLAGS, 8'h00);
    chk(wake_req, 1'b0);
    io_clk_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(`EPI_OFS_FLAGS, 8'h40);
    pin(6'h00);
    wb(1'b1, `EPI_OFS_MCU_CONTROL, 8'h00);
    repeat (6) @(posedge ref_clk);
    chk(irq_req.ext, 1'b1);
    chk(global_pullup_disable, 1'b0);
    chk({sleep_permit, sleep_select}, 3'h0);
    rd(`EPI_OFS_FLAGS, 8'h00);
    core_status_word_i <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(irq_req.ext, 1'b0);
    core_status_word_i <= 1'b1;
    // deep sleep: low level still wakes, a vanished level requests nothing
    deep_sleep <= 1'b1;
    io_clk_en <= 1'b0;
    pin(6'h02);
    chk(wake_req, 1'b0);
    pin(6'h00);
    chk(wake_req, 1'b1);
    chk(irq_req.ext, 1'b1);
    pin(6'h02);
    chk(irq_req.ext, 1'b0);
    // disabled pin is clamped; its release on resume reads as a rise
    wb(1'b1, `EPI_OFS_ENABLE, 8'h00);
    wb(1'b1, `EPI_OFS_MCU_CONTROL, 8'h03);
    rd(`EPI_OFS_FLAGS, 8'h00);
    deep_sleep <= 1'b0;
    io_clk_en <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`EPI_OFS_FLAGS, 8'h40);
    wb(1'b1, `EPI_OFS_MCU_CONTROL, 8'h00);
    pin(6'h00);
    k = $unsigned($random(seed)) % 6;
    mk = 6'h01 << k;
    wb(1'b1, `EPI_OFS_ENABLE, 8'h20);
    wb(1'b1, `EPI_OFS_PC_MASK, {2'h0, mk});
    wb(1'b1, `EPI_OFS_EVT_MASK, 8'h02);
    wb(1'b1, `EPI_OFS_FLAGS, 8'h60);
    wb(1'b1, `EPI_OFS_EVT_STATUS, 8'h03);
    deep_sleep <= 1'b1;
    io_clk_en <= 1'b0;
    pin(6'h01 << ((k + 1) % 6));
    rd(`EPI_OFS_FLAGS, 8'h00);
    pin((6'h01 << ((k + 1) % 6)) | mk);
    rd(`EPI_OFS_FLAGS, 8'h20);
    chk(irq_req.pc, 1'b1);
    chk(irq, 1'b1);
    deep_sleep <= 1'b0;
    io_clk_en <= 1'b1;
    @(posedge ref_clk) vector_ack_pc <= 1'b1;
    @(posedge ref_clk) vector_ack_pc <= 1'b0;
    rd(`EPI_OFS_FLAGS, 8'h00);
    wb(1'b1, `EPI_OFS_EVT_STATUS, 8'h03);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0);
    analog <= 6'($random(seed));
    repeat (4) @(posedge ref_clk);
    chk(ige, mk | analog);
    chk(igv, analog);
    finish_test;
  end
endmodule // external_pin_interrupts_tb
